// ### logic/csm_clock_ctrl.sv
`timescale 1ns/1ps
// Behaviour
// RULE_01: Source bit 1 makes pin input only
// RULE_02: Rate bit must match external clock rate
// RULE_03: Internal source times everything from oscillator
// RULE_04: Oscillator on per sleep, source, PWM
// RULE_05: PWM with slow external starts oscillator
// RULE_06: Oscillator stopped while reset asserted
// RULE_07: Clock pin released during reset
// RULE_08: Pin drive disabled after power-on
// RULE_09: Drive pin only internal and enabled
// RULE_10: Pin carries prescaled intermediate clock
// RULE_11: Sleeping undriven pin stays released
// RULE_12: Frame is integer division of clock
// RULE_13: Prescaler programs frame rate steps
// RULE_14: Host keeps external clock while display on
// RULE_15: Pair commands decode upper nibble
// RULE_16: Two-bit lane mode decode
// RULE_17: Oscillator command upper bits 00011
// RULE_18: Sleep reverts PWM lanes to static
// RULE_19: Intermediate clock from oscillator via prescaler
// RULE_20: Source switch without short pulses
module csm_clock_ctrl
   import csm_pkg::*;
#(
   parameter int LANES = 6
) (
   // Clock and reset
   input  wire logic             mclk,
   input  wire logic             srst,
   // Command byte from the serial front end
   input  wire logic             cmd_valid,
   input  wire logic [7:0]       cmd_byte,
   // Other control state
   input  wire logic             sleep_request,
   input  wire logic             pwm_enable,
   input  wire logic [LANES-1:0] pwm_level,
   input  wire logic [LANES-1:0] static_level,
   // Shared clock pin, split
   input  wire logic             shared_clock_pin_i,
   output logic                  shared_clock_pin_o,
   output logic                  shared_clock_pin_oe,
   // Status
   output logic                  osc_run_q,
   output logic                  timing_clk_q,
   output logic                  frame_tick_q,
   output logic [LANES-1:0]      lane_is_lcd_q,
   output logic [LANES-1:0]      static_level_output
);
   import csm_pkg::*;

   // Oscillator configuration bits
   logic             clock_source_select_q;
   logic             clock_pin_drive_enable_q;
   logic             ext_rate_select_q;
   logic [4:0]       fd_q;                      // Frame prescaler code
   logic [2*LANES-1:0] lane_mode_field_q;       // Two bits per lane
   logic [7:0]       osc_cnt_q;                 // Oscillator half period count
   logic             osc_clk_q;                 // Modelled 230 kHz oscillator
   logic             pin_s1_q, pin_s2_q, pin_s3_q; // External clock sync
   logic             sel_ext_q;                 // Glitch-free mux selection
   logic [6:0]       q_cnt_q;                   // Divide factor counter
   logic             inter_clk_q;               // Intermediate clock
   logic [5:0]       fr_cnt_q;                  // Divide by 48 counter
   logic             osc_on;
   logic             tick_src;
   logic             ext_edge;
   logic             osc_edge;
   logic             inter_edge;
   logic             rate_tick;

   // Divide factor lookup, small table kept as constants
   function automatic logic [6:0] div_q(input logic [4:0] fd);
      case (fd)
         5'h00: div_q = 7'd80;
         5'h01: div_q = 7'd68;
         5'h02: div_q = 7'd60;
         5'h03: div_q = 7'd53;
         5'h04: div_q = 7'd48;
         5'h05: div_q = 7'd44;
         5'h06: div_q = 7'd40;
         5'h07: div_q = 7'd37;
         5'h08: div_q = 7'd34;
         5'h09: div_q = 7'd32;
         5'h0A: div_q = 7'd30;
         5'h0B: div_q = 7'd28;
         5'h0C: div_q = 7'd27;
         5'h0D: div_q = 7'd25;
         5'h0E: div_q = 7'd24;
         5'h0F: div_q = 7'd23;
         5'h10: div_q = 7'd22;
         5'h11: div_q = 7'd21;
         5'h12: div_q = 7'd20;
         default: div_q = 7'd24; // Codes past the table fall to nominal
      endcase
   endfunction : div_q

   // Oscillator command register, defaults all zero
   always_ff @(posedge mclk) begin
      if (srst) begin
         clock_source_select_q    <= 1'b0;
         clock_pin_drive_enable_q <= 1'b0; // RULE_08
         ext_rate_select_q        <= 1'b0;
      end else if (cmd_valid && cmd_byte[7:3] == OSC_CMD_CODE) begin // RULE_17
         clock_source_select_q    <= cmd_byte[SRC_BIT];
         clock_pin_drive_enable_q <= cmd_byte[DRV_BIT];
         ext_rate_select_q        <= cmd_byte[RATE_BIT]; // RULE_02
      end
   end

   // Frame prescaler command
   always_ff @(posedge mclk) begin
      if (srst) begin
         fd_q <= FD_RESET;
      end else if (cmd_valid && cmd_byte[7:5] == FRAME_CMD_CODE) begin
         fd_q <= cmd_byte[4:0]; // RULE_13
      end
   end

   // Output pair mode commands: odd lane in 3:2, even lane in 1:0
   always_ff @(posedge mclk) begin
      if (srst) begin
         lane_mode_field_q <= '0;
      end else if (cmd_valid) begin
         case (cmd_byte[7:4]) // RULE_15
            PAIR01_CODE: lane_mode_field_q[3:0]   <= cmd_byte[3:0];
            PAIR23_CODE: lane_mode_field_q[7:4]   <= cmd_byte[3:0];
            PAIR45_CODE: lane_mode_field_q[11:8]  <= cmd_byte[3:0];
            default: begin
               // Other commands leave the lane modes alone
            end
         endcase
      end
   end

   // Oscillator enable: off in sleep and reset, else per source and PWM
   assign osc_on = !sleep_request && !srst && // RULE_04 RULE_06
                   (!clock_source_select_q || // RULE_03
                    (!ext_rate_select_q && pwm_enable)); // RULE_05

   // Oscillator model: toggles at about 230 kHz while enabled
   always_ff @(posedge mclk) begin
      if (srst || !osc_on) begin
         osc_cnt_q <= '0; // RULE_06
         osc_clk_q <= 1'b0;
         osc_run_q <= 1'b0;
      end else begin
         osc_run_q <= 1'b1;
         if (osc_cnt_q == 8'(OSC_HALF_CYC - 1)) begin
            osc_cnt_q <= '0;
            osc_clk_q <= ~osc_clk_q;
         end else begin
            osc_cnt_q <= osc_cnt_q + 8'h01;
         end
      end
   end

   // External clock synchroniser; stage one feeds stage two only
   always_ff @(posedge mclk) begin
      if (srst) begin
         pin_s1_q <= 1'b0;
         pin_s2_q <= 1'b0;
         pin_s3_q <= 1'b0;
      end else begin
         pin_s1_q <= shared_clock_pin_i;
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
      end
   end

   assign ext_edge = pin_s2_q && !pin_s3_q;
   assign osc_edge = osc_cnt_q == 8'(OSC_HALF_CYC - 1) && !osc_clk_q;

   // Source swaps only while both sources are low, so no short pulse
   always_ff @(posedge mclk) begin
      if (srst) begin
         sel_ext_q <= 1'b0;
      end else if (!osc_clk_q && !pin_s2_q) begin
         sel_ext_q <= clock_source_select_q; // RULE_20 RULE_01
      end
   end

   assign tick_src = sel_ext_q ? ext_edge : osc_edge; // RULE_03

   // Divide factor stage gives the intermediate clock
   always_ff @(posedge mclk) begin
      if (srst) begin
         q_cnt_q     <= '0;
         inter_clk_q <= 1'b0;
      end else if (tick_src) begin
         if (q_cnt_q >= div_q(fd_q) - 7'd1) begin // RULE_19
            q_cnt_q <= '0;
         end else begin
            q_cnt_q <= q_cnt_q + 7'd1;
         end
         // High for the lower half; odd factors give uneven duty
         inter_clk_q <= q_cnt_q < (div_q(fd_q) >> 1); // RULE_10
      end
   end

   assign inter_edge = tick_src && q_cnt_q == 7'd0;
   // A slow external clock skips the q stage and feeds 48 directly
   assign rate_tick  = (sel_ext_q && !ext_rate_select_q) ? tick_src : inter_edge; // RULE_12

   // Frame divider by 48
   always_ff @(posedge mclk) begin
      if (srst) begin
         fr_cnt_q     <= '0;
         frame_tick_q <= 1'b0;
      end else begin
         frame_tick_q <= 1'b0;
         if (rate_tick) begin
            if (fr_cnt_q == 6'(FRAME_BASE - 1)) begin
               fr_cnt_q     <= '0;
               frame_tick_q <= 1'b1; // RULE_12
            end else begin
               fr_cnt_q <= fr_cnt_q + 6'd1;
            end
         end
      end
   end

   // Registered timing clock for LCD and PWM logic
   always_ff @(posedge mclk) begin
      if (srst) begin
         timing_clk_q <= 1'b0;
      end else begin
         timing_clk_q <= sel_ext_q ? pin_s2_q : osc_clk_q;
      end
   end

   // Pin driver: internal source and drive enable only; high in sleep
   always_ff @(posedge mclk) begin
      if (srst) begin
         shared_clock_pin_oe <= 1'b0; // RULE_07
         shared_clock_pin_o  <= 1'b0;
      end else begin
         shared_clock_pin_oe <= !clock_source_select_q &&
                                clock_pin_drive_enable_q; // RULE_09 RULE_11
         shared_clock_pin_o  <= sleep_request ? 1'b1 : inter_clk_q; // RULE_10
      end
   end

   // Lane decode; PWM lanes fall back to static level in sleep
   always_ff @(posedge mclk) begin
      if (srst) begin
         lane_is_lcd_q       <= '1;
         static_level_output <= '0;
      end else begin
         for (int i = 0; i < LANES; i++) begin
            case (csm_mode_e'(lane_mode_field_q[2*i +: 2])) // RULE_16
               CSM_STATIC: begin
                  lane_is_lcd_q[i]       <= 1'b0;
                  static_level_output[i] <= static_level[i];
               end
               CSM_PWM: begin
                  lane_is_lcd_q[i]       <= 1'b0;
                  static_level_output[i] <= (sleep_request || !osc_run_q) ?
                                            static_level[i] : pwm_level[i]; // RULE_18
               end
               default: begin
                  lane_is_lcd_q[i]       <= 1'b1;
                  static_level_output[i] <= 1'b0;
               end
            endcase
         end
      end
   end

   // Checks
   property p_osc_off_sleep;
      @(posedge mclk) disable iff (srst) sleep_request |=> !osc_run_q;
   endproperty
   a_osc_off_sleep: assert property (p_osc_off_sleep) else $error("osc runs in sleep"); // RULE_04

   property p_osc_slow_pwm;
      @(posedge mclk) disable iff (srst)
         (clock_source_select_q && !ext_rate_select_q && pwm_enable && !sleep_request)[*2]
         |-> osc_run_q;
   endproperty
   a_osc_slow_pwm: assert property (p_osc_slow_pwm) else $error("osc idle for pwm"); // RULE_05

   property p_pin_src;
      @(posedge mclk) disable iff (srst) shared_clock_pin_oe |-> $past(!clock_source_select_q);
   endproperty
   a_pin_src: assert property (p_pin_src) else $error("pin driven with external"); // RULE_09

   property p_pin_reset;
      @(posedge mclk) srst |=> !shared_clock_pin_oe;
   endproperty
   a_pin_reset: assert property (p_pin_reset) else $error("pin driven after reset"); // RULE_07

   property p_osc_reset;
      @(posedge mclk) srst |=> !osc_run_q;
   endproperty
   a_osc_reset: assert property (p_osc_reset) else $error("osc runs in reset"); // RULE_06

   property p_fd_load;
      @(posedge mclk) disable iff (srst)
         cmd_valid && cmd_byte[7:5] == FRAME_CMD_CODE |=> fd_q == $past(cmd_byte[4:0]);
   endproperty
   a_fd_load: assert property (p_fd_load) else $error("prescaler not loaded"); // RULE_13

   property p_pair_load;
      @(posedge mclk) disable iff (srst)
         cmd_valid && cmd_byte[7:4] == PAIR23_CODE
         |=> lane_mode_field_q[7:4] == $past(cmd_byte[3:0]);
   endproperty
   a_pair_load: assert property (p_pair_load) else $error("pair mode not loaded"); // RULE_15

   property p_frame_tick;
      @(posedge mclk) disable iff (srst) frame_tick_q |=> !frame_tick_q;
   endproperty
   a_frame_tick: assert property (p_frame_tick) else $error("frame tick too long"); // RULE_12

   // Internal source keeps the oscillator running while awake
   property p_osc_int;
      @(posedge mclk) disable iff (srst)
         !clock_source_select_q && !sleep_request |=> osc_run_q;
   endproperty
   a_osc_int: assert property (p_osc_int) else $error("osc idle on internal"); // RULE_03

   // External source never drives the pin, whatever the drive bit holds
   property p_src_pin;
      @(posedge mclk) disable iff (srst) clock_source_select_q |=> !shared_clock_pin_oe;
   endproperty
   a_src_pin: assert property (p_src_pin) else $error("pin driven on external"); // RULE_01

   // Sleep parks the pin data high, so a driven pin shows a steady level
   property p_pin_sleep;
      @(posedge mclk) disable iff (srst) sleep_request |=> shared_clock_pin_o;
   endproperty
   a_pin_sleep: assert property (p_pin_sleep) else $error("pin not high in sleep"); // RULE_11

   // Mode bit 1 alone splits segment lanes from static and PWM lanes
   property p_lane_lcd;
      @(posedge mclk) disable iff (srst) lane_is_lcd_q[0] == $past(!lane_mode_field_q[1]);
   endproperty
   a_lane_lcd: assert property (p_lane_lcd) else $error("lane 0 kind wrong"); // RULE_16

   // A sleeping PWM lane shows its static level one edge later
   property p_pwm_sleep;
      @(posedge mclk) disable iff (srst) sleep_request && lane_mode_field_q[3:2] == CSM_PWM
         |=> static_level_output[1] == $past(static_level[1]);
   endproperty
   a_pwm_sleep: assert property (p_pwm_sleep) else $error("pwm lane live in sleep"); // RULE_18
endmodule : csm_clock_ctrl

// ### logic/csm_pkg.sv
package csm_pkg;
   // Command opcode fields
   localparam logic [4:0] OSC_CMD_CODE   = 5'h03;  // Upper five bits 00011
   localparam logic [3:0] PAIR01_CODE    = 4'hC;   // Pair 0/1 selector
   localparam logic [3:0] PAIR23_CODE    = 4'hD;   // Pair 2/3 selector
   localparam logic [3:0] PAIR45_CODE    = 4'hE;   // Pair 4/5 selector
   localparam logic [2:0] FRAME_CMD_CODE = 3'h1;   // Frame prescaler command
   // Oscillator command bit positions
   localparam int         SRC_BIT        = 0;
   localparam int         DRV_BIT        = 1;
   localparam int         RATE_BIT       = 2;
   // Reset values
   localparam logic [4:0] FD_RESET       = 5'h0E;  // Divide factor 24
   localparam logic [1:0] MODE_RESET     = 2'h0;
   // Frame divider base
   localparam int         FRAME_BASE     = 48;
   // Nominal internal oscillator
   localparam int         OSC_KHZ        = 230;
   localparam int         CLK_MHZ        = 100;
   localparam int         OSC_HALF_CYC   = (CLK_MHZ * 1000) / (2 * OSC_KHZ);
   // Output lane modes
   typedef enum logic [1:0] {
      CSM_LCD0   = 2'b00,
      CSM_LCD1   = 2'b01,
      CSM_STATIC = 2'b10,
      CSM_PWM    = 2'b11
   } csm_mode_e;
endpackage : csm_pkg

// ### tb/csm_host.sv
`timescale 1ns/1ps
// Host side: issues command bytes and may supply the external clock
module csm_host (
   // Clock
   input  wire logic       mclk,
   // Command path toward the device
   output logic            cmd_valid,
   output logic [7:0]      cmd_byte,
   // Level the host puts on the shared clock pin
   output logic            ext_pin
);
   logic ext_on;   // External clock supplied
   int   ext_half; // Half period in mclk cycles
   int   cnt;      // Half period counter

   initial begin
      cmd_valid = 1'b0;
      cmd_byte  = 8'h00;
      ext_pin   = 1'b0;
      ext_on    = 1'b0;
      ext_half  = 20;
      cnt       = 0;
   end

   // One command per call, valid for exactly one edge
   task send(input logic [7:0] b);
      @(posedge mclk);
      cmd_valid <= 1'b1;
      cmd_byte  <= b;
      @(posedge mclk);
      cmd_valid <= 1'b0;
      cmd_byte  <= ~b; // Stale byte is not left on the bus
   endtask : send

   // External clock runs for as long as the display needs it
   always @(posedge mclk) begin
      if (ext_on) begin
         cnt <= (cnt >= ext_half - 1) ? 0 : cnt + 1;
         if (cnt >= ext_half - 1) begin
            ext_pin <= ~ext_pin;
         end
      end else begin
         ext_pin <= ~ext_pin; // Floating pin: no stable value to lean on
      end
   end
endmodule : csm_host

// ### tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import csm_pkg::*;
   // Oscillator command table: {pwm, cmd, oe, run}
   localparam logic [10:0] OT [6] = '{11'h06B, 11'h061, 11'h06C, 11'h465, 11'h474, 11'h47C};
   logic       mclk = 1'b0;     // 100 MHz
   logic       srst;            // Sync reset
   logic       sleep_request;   // Power-down request
   logic       pwm_enable;      // PWM in use
   logic [5:0] pwm_level;       // Levels from the PWM generator
   logic [5:0] static_level;    // Programmed static levels
   logic       cmd_valid, pin_o, pin_oe, ext_pin, osc_run, tclk, tick;
   logic [7:0] cmd_byte;
   logic [5:0] lcd, lvl;
   wire        pin_i = pin_oe ? pin_o : ext_pin; // Resolved pin level
   int         num_errors = 0;
   int         checks_done = 0;
   int         n;

   always #5 mclk = ~mclk;

   csm_host host (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .ext_pin(ext_pin));

   csm_clock_ctrl #(.LANES(6)) DUT (
      .mclk(mclk), .srst(srst), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
      .sleep_request(sleep_request), .pwm_enable(pwm_enable), .pwm_level(pwm_level),
      .static_level(static_level), .shared_clock_pin_i(pin_i), .shared_clock_pin_o(pin_o),
      .shared_clock_pin_oe(pin_oe), .osc_run_q(osc_run), .timing_clk_q(tclk),
      .frame_tick_q(tick), .lane_is_lcd_q(lcd), .static_level_output(lvl));

   // Settle past the edge before looking
   task step(input int k);
      repeat (k) @(posedge mclk);
      #1;
   endtask : step

   task chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   function automatic logic sig(input int w);
      return (w == 0) ? tclk : (w == 1) ? pin_o : tick;
   endfunction : sig

   // Cycles between two rising edges of a watched output
   task period(input int w, output int cnt);
      logic p;
      int   r;
      cnt = 0;
      r = 0;
      p = sig(w);
      while (r < 2 && cnt < 40000) begin
         step(1);
         if (r == 1) cnt++;
         if (p === 1'b0 && sig(w) === 1'b1) r++;
         p = sig(w);
      end
   endtask : period

   task close_out;
      $display("checks=%0d errors=%0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : close_out

   // Hang guard, well beyond the longest test
   initial begin
      repeat (100000) @(posedge mclk);
      num_errors++;
      close_out();
   end

   initial begin
      srst          <= 1'b1;
      sleep_request <= 1'b0;
      pwm_enable    <= 1'b0;
      pwm_level     <= 6'h33;
      static_level  <= 6'h0F;
      step(8);
      chk(pin_oe, 1'b0);
      chk(osc_run, 1'b0);
      @(posedge mclk) srst <= 1'b0;
      step(3);
      chk({pin_oe, pin_o}, 2'h0);
      chk({lcd, lvl}, 12'hFC0);
      $display("test reset done");
      // Six of the eight source, drive and rate settings
      for (int i = 0; i < 6; i++) begin
         @(posedge mclk) pwm_enable <= OT[i][10];
         host.send(OT[i][9:2]);
         step(4);
         chk(pin_oe, OT[i][1]);
         chk(osc_run, OT[i][0]);
      end
      @(posedge mclk) pwm_enable <= 1'b0;
      host.send(8'h1A);
      host.send(8'hF3); // Unmatched byte, ignored
      host.send(8'h13);
      step(4);
      chk(pin_oe, 1'b1);
      $display("test osc done");
      // Sleep with and without pin drive
      @(posedge mclk) sleep_request <= 1'b1;
      step(4);
      chk({osc_run, pin_oe, pin_o}, 3'h3);
      host.send(8'h18);
      step(4);
      chk(pin_oe, 1'b0);
      @(posedge mclk) sleep_request <= 1'b0;
      $display("test sleep done");
      // Odd lanes PWM, even lanes static, on all pairs
      host.send({PAIR01_CODE, 4'hE});
      host.send({PAIR23_CODE, 4'hE});
      host.send({PAIR45_CODE, 4'hE});
      step(4);
      chk({lcd, lvl}, 12'h027);
      @(posedge mclk) sleep_request <= 1'b1;
      step(4);
      chk(lvl, 6'h0F);
      @(posedge mclk) static_level <= 6'h2A;
      step(4);
      chk(lvl, 6'h2A);
      @(posedge mclk) sleep_request <= 1'b0;
      pwm_level <= 6'h1C;
      host.send(8'hC5);
      host.send(8'hD9);
      step(4);
      chk({lcd, lvl}, 12'h1C8);
      $display("test lanes done");
      // Internal clock and pin clock periods
      period(0, n);
      chk(n, 2 * OSC_HALF_CYC);
      host.send(8'h1A);
      step(4);
      period(1, n);
      chk(n, 48 * OSC_HALF_CYC);
      // Prescaler code 0x12 gives a divide factor of 20
      host.send(8'h32);
      step(4);
      period(1, n);
      chk(n, 40 * OSC_HALF_CYC);
      $display("test clocks done");
      // Slow external clock: frame every 48 of its cycles
      host.ext_on = 1'b1;
      host.send(8'h19);
      step(4);
      period(2, n);
      chk(n, 48 * 2 * host.ext_half);
      $display("test frame done");
      close_out();
   end
endmodule : tb_top
